// File: hdl/ptri_range_inval.sv
// Purpose: Decode and perform range invalidations of protection table entries
// Assumes: APB slave, zero wait states, 10 MHz pclk
// Notes:   Broadcast goes out as a request/acknowledge pair to the domain
//
// Operation
// - Size codes 4..9 map to 32MB..512GB
// - Reserved size code: skip invalidation
// - Span below granule uses granule size
// - Reserved granule setting: skip invalidation
// - Granule setting selects 4KB, 16KB, 64KB
// - Base address from operand by granule
// - Misaligned base: skip invalidation
// - Only highest privilege level; else undefined
// - Without realm feature: always undefined
// - All-levels variant drops every level
// - Broadcast to whole outer shareable domain
// - Last-level variant at its fixed encoding
// - Completion like other translation invalidations
// - Touch only protection table entries
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ns
module ptri_range_inval #(
    parameter int N = ptri_pkg::ENTRIES
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      fill_valid,
    input  wire logic [ptri_pkg::PA_W-1:0] fill_addr,
    input  wire logic                      fill_last,
    output logic                           bcast_req,
    output logic      [ptri_pkg::PA_W-1:0] bcast_base,
    output logic      [5:0]                bcast_lg,
    output logic                           bcast_last_only,
    input  wire logic                      bcast_ack,
    output logic      [N-1:0]              entry_valid
);
    typedef enum logic [1:0] {
        PTRI_IDLE = 2'b00,  // Waiting for launch
        PTRI_LOCAL = 2'b01, // Local invalidate cycle
        PTRI_BCAST = 2'b10  // Waiting for domain acknowledge
    } ptri_state_e;

    ptri_state_e               st_reg, st_next;         // Sequencer
    logic [5:0]                ctrl_reg, ctrl_next;     // Control
    logic [63:0]               oper_reg, oper_next;     // Operand register
    logic [15:0]               enc_reg, enc_next;       // Instruction encoding
    logic [5:0]                stat_reg, stat_next;     // Status flags
    logic [ptri_pkg::PA_W-1:0] base_reg, base_next;     // Effective base
    logic [5:0]                lg_reg, lg_next;         // Effective span log2
    logic                      lo_reg, lo_next;         // Last-level variant
    logic [31:0]               cnt_reg, cnt_next;       // Completed broadcasts
    logic                      wr, rd;                  // APB access strobes
    logic [ptri_pkg::PA_W-1:0] dec_base;                // Decoded base
    logic [5:0]                dec_lg, gran_lg;         // Decoded spans
    logic                      sz_ok, pgs_ok, aligned;  // Decode checks
    logic                      is_ll, is_al;            // Encoding match
    logic                      priv_ok;                 // Level and feature check

    // Span log2 of a size code; zero marks reserved
    function automatic logic [5:0] size_lg(input logic [3:0] code);
        case (code)
            ptri_pkg::SZ_32M:  size_lg = ptri_pkg::LG_32M;
            ptri_pkg::SZ_512M: size_lg = ptri_pkg::LG_512M;
            ptri_pkg::SZ_1G:   size_lg = ptri_pkg::LG_1G;
            ptri_pkg::SZ_16G:  size_lg = ptri_pkg::LG_16G;
            ptri_pkg::SZ_64G:  size_lg = ptri_pkg::LG_64G;
            ptri_pkg::SZ_512G: size_lg = ptri_pkg::LG_512G;
            default:           size_lg = 6'd0;
        endcase
    endfunction

    // Granule log2 of a granule setting; zero marks reserved
    function automatic logic [5:0] gran_log(input logic [1:0] physical_granule_select);
        case (physical_granule_select)
            ptri_pkg::PGS_4K:  gran_log = ptri_pkg::LG_4K;
            ptri_pkg::PGS_16K: gran_log = ptri_pkg::LG_16K;
            ptri_pkg::PGS_64K: gran_log = ptri_pkg::LG_64K;
            default:           gran_log = 6'd0;
        endcase
    endfunction

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    // Operand decode
    always_comb begin
        logic [1:0] physical_granule_select;
        logic [5:0] slg;
        physical_granule_select      = ctrl_reg[ptri_pkg::CTRL_PGS_LO +: 2];
        gran_lg  = gran_log(physical_granule_select);
        pgs_ok   = (gran_lg != 6'd0);
        slg      = size_lg(oper_reg[ptri_pkg::OP_SIZE_LO +: 4]);
        sz_ok    = (slg != 6'd0);
        dec_lg   = (slg < gran_lg) ? gran_lg : slg;
        dec_base = '0;
        // Operand bits 63:48 and 43:40 ignored; software keeps them zero
        case (physical_granule_select)
            ptri_pkg::PGS_4K:  dec_base[51:12] = oper_reg[39:0];
            ptri_pkg::PGS_16K: dec_base[51:14] = oper_reg[39:2];
            ptri_pkg::PGS_64K: dec_base[51:16] = oper_reg[39:4];
            default:           dec_base = '0;
        endcase
        aligned = ((dec_base & ((52'h1 << dec_lg) - 52'h1)) == '0);
        is_ll   = (enc_reg == {ptri_pkg::ENC_OP0, ptri_pkg::ENC_OP1, ptri_pkg::ENC_CRN,
                               ptri_pkg::ENC_CRM_LL, ptri_pkg::ENC_OP2_LL});
        is_al   = (enc_reg == {ptri_pkg::ENC_OP0, ptri_pkg::ENC_OP1, ptri_pkg::ENC_CRN,
                               ptri_pkg::ENC_CRM_AL, ptri_pkg::ENC_OP2_AL});
        priv_ok = ctrl_reg[ptri_pkg::CTRL_FEAT] &&
                  (ctrl_reg[ptri_pkg::CTRL_EL_LO +: 2] == ptri_pkg::EL_TOP);
    end

    // Sequencer and register file next state
    always_comb begin
        st_next   = st_reg;
        ctrl_next = ctrl_reg;
        oper_next = oper_reg;
        enc_next  = enc_reg;
        stat_next = stat_reg;
        base_next = base_reg;
        lg_next   = lg_reg;
        lo_next   = lo_reg;
        cnt_next  = cnt_reg;
        ctrl_next[ptri_pkg::CTRL_GO] = 1'b0; // Launch bit self-clears
        // Register writes, refused while busy
        if (wr && st_reg == PTRI_IDLE) begin
            case (paddr)
                ptri_pkg::OFF_CTRL:     ctrl_next = pwdata[5:0];
                ptri_pkg::OFF_OPER_LO:  oper_next[31:0] = pwdata;
                ptri_pkg::OFF_OPER_HI:  oper_next[63:32] = pwdata;
                ptri_pkg::OFF_ENCODING: enc_next = pwdata[15:0];
                default:                ;
            endcase
        end
        case (st_reg)
            PTRI_IDLE: begin
                if (ctrl_reg[ptri_pkg::CTRL_GO]) begin
                    stat_next = '0;
                    if (!priv_ok || !(is_ll || is_al)) begin
                        stat_next[ptri_pkg::ST_UNDEF] = 1'b1; // Undefined instruction
                        stat_next[ptri_pkg::ST_DONE]  = 1'b1;
                    end else if (!pgs_ok || !sz_ok || !aligned) begin
                        stat_next[ptri_pkg::ST_SKIP] = 1'b1; // Nothing required
                        stat_next[ptri_pkg::ST_DONE] = 1'b1;
                        stat_next[ptri_pkg::ST_LAST] = is_ll;
                    end else begin
                        base_next = dec_base;
                        lg_next   = dec_lg;
                        lo_next   = is_ll;
                        stat_next[ptri_pkg::ST_BUSY] = 1'b1;
                        stat_next[ptri_pkg::ST_LAST] = is_ll;
                        st_next   = PTRI_LOCAL;
                    end
                end
            end
            PTRI_LOCAL: st_next = PTRI_BCAST; // Own cache dropped this cycle
            PTRI_BCAST: begin
                if (bcast_ack) begin
                    stat_next[ptri_pkg::ST_BUSY] = 1'b0;
                    stat_next[ptri_pkg::ST_DONE] = 1'b1;
                    stat_next[ptri_pkg::ST_EXEC] = 1'b1;
                    cnt_next = cnt_reg + 32'd1;
                    st_next  = PTRI_IDLE;
                end
            end
            default: st_next = PTRI_IDLE;
        endcase
    end

    // Register all state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg   <= PTRI_IDLE;
            ctrl_reg <= ptri_pkg::CTRL_RESET;
            oper_reg <= '0;
            enc_reg  <= '0;
            stat_reg <= '0;
            base_reg <= '0;
            lg_reg   <= '0;
            lo_reg   <= 1'b0;
            cnt_reg  <= '0;
            prdata   <= '0;
        end else begin
            st_reg   <= st_next;
            ctrl_reg <= ctrl_next;
            oper_reg <= oper_next;
            enc_reg  <= enc_next;
            stat_reg <= stat_next;
            base_reg <= base_next;
            lg_reg   <= lg_next;
            lo_reg   <= lo_next;
            cnt_reg  <= cnt_next;
            // Read data captured in setup phase
            if (rd) begin
                case (paddr)
                    ptri_pkg::OFF_CTRL:     prdata <= {26'h0, ctrl_reg};
                    ptri_pkg::OFF_OPER_LO:  prdata <= oper_reg[31:0];
                    ptri_pkg::OFF_OPER_HI:  prdata <= oper_reg[63:32];
                    ptri_pkg::OFF_ENCODING: prdata <= {16'h0, enc_reg};
                    ptri_pkg::OFF_STATUS:   prdata <= {26'h0, stat_reg};
                    ptri_pkg::OFF_BASE_LO:  prdata <= base_reg[31:0];
                    ptri_pkg::OFF_BASE_HI:  prdata <= {12'h0, base_reg[51:32]};
                    ptri_pkg::OFF_SPAN:     prdata <= {26'h0, lg_reg};
                    ptri_pkg::OFF_COUNT:    prdata <= cnt_reg;
                    default:                prdata <= 32'h0;
                endcase
            end
        end
    end

    // Zero wait states; unmapped or busy write answers with error
    assign pready  = 1'b1;
    assign pslverr = psel && penable &&
                     ((paddr > ptri_pkg::OFF_COUNT) || (paddr[1:0] != 2'h0) ||
                      (pwrite && st_reg != PTRI_IDLE));

    // Broadcast request to the outer shareable domain
    assign bcast_req       = (st_reg == PTRI_BCAST);
    assign bcast_base      = base_reg;
    assign bcast_lg        = lg_reg;
    assign bcast_last_only = lo_reg;

    // Own cache drops the same range; wider drops would also be legal
    ptri_entry_cache #(.N(N)) u_ptri_entry_cache (
        .pclk          (pclk),
        .presetn       (presetn),
        .fill_valid    (fill_valid),
        .fill_addr     (fill_addr),
        .fill_last     (fill_last),
        .inv_valid     (st_reg == PTRI_LOCAL),
        .inv_base      (base_reg),
        .inv_lg        (lg_reg),
        .inv_last_only (lo_reg),
        .valid_map     (entry_valid)
    );
endmodule // ptri_range_inval

// File: hdl/ptri_pkg.sv
// Purpose: Constants for the protection table range invalidation block
// Assumes: APB register access, 32-bit data, word-aligned registers
// Notes:   Offsets, field positions and encodings shared by the design
package ptri_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00; // Control and launch
    localparam logic [7:0] OFF_OPER_LO  = 8'h04; // Operand bits 31:0
    localparam logic [7:0] OFF_OPER_HI  = 8'h08; // Operand bits 63:32
    localparam logic [7:0] OFF_ENCODING = 8'h0c; // System instruction encoding
    localparam logic [7:0] OFF_STATUS   = 8'h10; // Result status
    localparam logic [7:0] OFF_BASE_LO  = 8'h14; // Base address bits 31:0
    localparam logic [7:0] OFF_BASE_HI  = 8'h18; // Base address bits 51:32
    localparam logic [7:0] OFF_SPAN     = 8'h1c; // Effective range log2
    localparam logic [7:0] OFF_COUNT    = 8'h20; // Completed broadcasts
    // Control fields
    localparam int CTRL_GO      = 0;  // Write 1 launches, self-clearing
    localparam int CTRL_PGS_LO  = 1;  // Granule size setting, bits 2:1
    localparam int CTRL_EL_LO   = 3;  // Current privilege level, bits 4:3
    localparam int CTRL_FEAT    = 5;  // Realm management feature present
    localparam logic [5:0] CTRL_RESET = 6'h20; // Feature present, 4KB, level 0
    // Status fields
    localparam int ST_BUSY  = 0;
    localparam int ST_DONE  = 1;
    localparam int ST_UNDEF = 2;
    localparam int ST_SKIP  = 3;
    localparam int ST_LAST  = 4;
    localparam int ST_EXEC  = 5;
    // Encoding fields of the instruction word {op0,op1,crn,crm,op2}
    localparam logic [1:0] ENC_OP0    = 2'h1;
    localparam logic [2:0] ENC_OP1    = 3'h6;
    localparam logic [3:0] ENC_CRN    = 4'h8;
    localparam logic [3:0] ENC_CRM_LL = 4'h4; // Last-level variant
    localparam logic [3:0] ENC_CRM_AL = 4'h4; // All-levels variant: same table, op2 differs
    localparam logic [2:0] ENC_OP2_LL = 3'h7;
    localparam logic [2:0] ENC_OP2_AL = 3'h3;
    // Granule size setting encodings
    localparam logic [1:0] PGS_4K  = 2'h0;
    localparam logic [1:0] PGS_64K = 2'h1;
    localparam logic [1:0] PGS_16K = 2'h2;
    localparam logic [1:0] EL_TOP  = 2'h3; // Highest privilege level
    // Operand fields
    localparam int OP_SIZE_LO = 44;
    localparam int OP_ADDR_HI = 39;
    localparam int PA_W       = 52;
    // Range size codes and their log2 spans
    localparam logic [3:0] SZ_32M  = 4'h4;
    localparam logic [3:0] SZ_512M = 4'h5;
    localparam logic [3:0] SZ_1G   = 4'h6;
    localparam logic [3:0] SZ_16G  = 4'h7;
    localparam logic [3:0] SZ_64G  = 4'h8;
    localparam logic [3:0] SZ_512G = 4'h9;
    localparam logic [5:0] LG_4K   = 6'd12;
    localparam logic [5:0] LG_16K  = 6'd14;
    localparam logic [5:0] LG_64K  = 6'd16;
    localparam logic [5:0] LG_32M  = 6'd25;
    localparam logic [5:0] LG_512M = 6'd29;
    localparam logic [5:0] LG_1G   = 6'd30;
    localparam logic [5:0] LG_16G  = 6'd34;
    localparam logic [5:0] LG_64G  = 6'd36;
    localparam logic [5:0] LG_512G = 6'd39;
    // Cache geometry default
    localparam int ENTRIES = 8;
endpackage

// File: hdl/ptri_entry_cache.sv
// Purpose: Small cache of protection table entries with range invalidation
// Assumes: One fill or one invalidate per cycle; invalidate wins on clash
// Notes:   Each entry holds a physical address, a walk level flag, a valid bit
`timescale 1ns/1ns
module ptri_entry_cache #(
    parameter int N = ptri_pkg::ENTRIES
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      fill_valid,
    input  wire logic [ptri_pkg::PA_W-1:0] fill_addr,
    input  wire logic                      fill_last,
    input  wire logic                      inv_valid,
    input  wire logic [ptri_pkg::PA_W-1:0] inv_base,
    input  wire logic [5:0]                inv_lg,
    input  wire logic                      inv_last_only,
    output logic      [N-1:0]              valid_map
);
    logic [ptri_pkg::PA_W-1:0] addr_reg [N];    // Entry addresses
    logic [ptri_pkg::PA_W-1:0] addr_next [N];
    logic [N-1:0]              last_reg;        // Entry came from final level
    logic [N-1:0]              last_next;
    logic [N-1:0]              vld_reg;         // Entry valid
    logic [N-1:0]              vld_next;
    logic [$clog2(N)-1:0]      ptr_reg;         // Round-robin fill slot
    logic [$clog2(N)-1:0]      ptr_next;
    logic [ptri_pkg::PA_W-1:0] mask;            // High-bit compare mask

    // Next state: invalidate by range, else fill
    always_comb begin
        mask = ~((52'h1 << inv_lg) - 52'h1);
        addr_next = addr_reg;
        last_next = last_reg;
        vld_next  = vld_reg;
        ptr_next  = ptr_reg;
        if (inv_valid) begin
            for (int i = 0; i < N; i++) begin
                // Only addresses inside the range; last-level variant only final-level entries
                if (((addr_reg[i] & mask) == (inv_base & mask)) &&
                    (!inv_last_only || last_reg[i])) begin
                    vld_next[i] = 1'b0;
                end
            end
        end else if (fill_valid) begin
            addr_next[ptr_reg] = fill_addr;
            last_next[ptr_reg] = fill_last;
            vld_next[ptr_reg]  = 1'b1;
            ptr_next = ptr_reg + 1'b1;
        end
    end

    // Register the entry array
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < N; i++) begin
                addr_reg[i] <= '0;
            end
            last_reg <= '0;
            vld_reg  <= '0;
            ptr_reg  <= '0;
        end else begin
            addr_reg <= addr_next;
            last_reg <= last_next;
            vld_reg  <= vld_next;
            ptr_reg  <= ptr_next;
        end
    end

    assign valid_map = vld_reg;
endmodule // ptri_entry_cache

// File: bench/ptri_range_inval_checker.sv
// Purpose: Port checks for the range invalidation block
// Assumes: One clock domain, bound to the top module
// Notes:   Helper regs mirror accepted control and encoding writes
`timescale 1ns/1ns
module ptri_range_inval_checker (
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [7:0]                paddr,
    input wire logic [31:0]               pwdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    input wire logic                      bcast_req,
    input wire logic [ptri_pkg::PA_W-1:0] bcast_base,
    input wire logic [5:0]                bcast_lg,
    input wire logic                      bcast_last_only,
    input wire logic                      bcast_ack
);
    localparam logic [15:0] ENC_LL = {ptri_pkg::ENC_OP0, ptri_pkg::ENC_OP1, ptri_pkg::ENC_CRN,
                                      ptri_pkg::ENC_CRM_LL, ptri_pkg::ENC_OP2_LL};
    logic [5:0]  ctl_reg, ctl_next;  // Last accepted control word
    logic [15:0] enc_reg, enc_next;  // Last accepted encoding
    logic [5:0]  glg;                // Granule span log2
    wire         wr_ok = psel && penable && pwrite && pready && !pslverr;
    // Next values of the mirrors
    always_comb begin
        ctl_next = ctl_reg;
        enc_next = enc_reg;
        if (wr_ok && paddr == ptri_pkg::OFF_CTRL) ctl_next = pwdata[5:0];
        if (wr_ok && paddr == ptri_pkg::OFF_ENCODING) enc_next = pwdata[15:0];
        glg = (ctl_reg[2:1] == ptri_pkg::PGS_64K) ? ptri_pkg::LG_64K :
              (ctl_reg[2:1] == ptri_pkg::PGS_16K) ? ptri_pkg::LG_16K : ptri_pkg::LG_4K;
    end
    // Mirror registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_reg <= 6'h20;
            enc_reg <= 16'h0;
        end else begin
            ctl_reg <= ctl_next;
            enc_reg <= enc_next;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_req_hold; bcast_req && !bcast_ack |=> bcast_req; endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped early");
    property p_req_drop; bcast_req && bcast_ack |=> !bcast_req; endproperty
    a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
    property p_stable;
        bcast_req && !bcast_ack |=>
            $stable(bcast_base) && $stable(bcast_lg) && $stable(bcast_last_only);
    endproperty
    a_stable: assert property (p_stable) else $error("broadcast fields moved");
    property p_lg;
        bcast_req |-> bcast_lg inside {6'd25, 6'd29, 6'd30, 6'd34, 6'd36, 6'd39};
    endproperty
    a_lg: assert property (p_lg) else $error("illegal span");
    property p_floor; bcast_req |-> bcast_lg >= glg; endproperty
    a_floor: assert property (p_floor) else $error("span below granule");
    property p_aligned;
        bcast_req |-> (bcast_base & ((52'h1 << bcast_lg) - 52'h1)) == 52'h0;
    endproperty
    a_aligned: assert property (p_aligned) else $error("misaligned broadcast");
    property p_low; bcast_req |-> (bcast_base & ((52'h1 << glg) - 52'h1)) == 52'h0; endproperty
    a_low: assert property (p_low) else $error("low base bits set");
    property p_priv; $rose(bcast_req) |-> ctl_reg[4:3] == ptri_pkg::EL_TOP; endproperty
    a_priv: assert property (p_priv) else $error("broadcast below top level");
    property p_feat; $rose(bcast_req) |-> ctl_reg[5]; endproperty
    a_feat: assert property (p_feat) else $error("broadcast without feature");
    property p_pgs; $rose(bcast_req) |-> ctl_reg[2:1] != 2'h3; endproperty
    a_pgs: assert property (p_pgs) else $error("broadcast on reserved granule");
    property p_var; $rose(bcast_req) |-> bcast_last_only == (enc_reg == ENC_LL); endproperty
    a_var: assert property (p_var) else $error("wrong variant");
endmodule // ptri_range_inval_checker
bind ptri_range_inval ptri_range_inval_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .bcast_req(bcast_req), .bcast_base(bcast_base), .bcast_lg(bcast_lg),
    .bcast_last_only(bcast_last_only), .bcast_ack(bcast_ack));

// File: bench/tb_ptri_range_inval.sv
// Purpose: Self-checking bench for the range invalidation block
// Assumes: APB master tasks, bench acks the broadcast
// Notes:   Decode expectations are modelled from the operand layout
`timescale 1ns/1ns
module tb_ptri_range_inval;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;                       // Byte address
    logic [31:0] pwdata, prdata, q;           // Bus data
    logic        e, fill_valid, fill_last;    // Error, cache fill
    logic [51:0] fill_addr, bcast_base, cap_base;
    logic [5:0]  bcast_lg, cap_lg;            // Broadcast span
    logic        bcast_req, bcast_last_only, bcast_ack, cap_last;
    logic [7:0]  entry_valid;                 // Local cache map
    logic [1:0]  pg;                          // Granule code
    int          miscompares, checks_done, nreq, dly, exp_count;
    // Bus clock, 100 ns period
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    ptri_range_inval #(.N(8)) u_ptri_range_inval (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fill_valid(fill_valid), .fill_addr(fill_addr), .fill_last(fill_last),
        .bcast_req(bcast_req), .bcast_base(bcast_base), .bcast_lg(bcast_lg),
        .bcast_last_only(bcast_last_only), .bcast_ack(bcast_ack), .entry_valid(entry_valid));
    // Domain stand-in: acks after dly+1 request cycles, records the request
    always @(posedge pclk) begin
        if (bcast_req && !bcast_ack) begin
            cap_base  <= bcast_base;
            cap_lg    <= bcast_lg;
            cap_last  <= bcast_last_only;
            nreq      <= nreq + 1;
            bcast_ack <= (nreq >= dly);
        end else begin
            bcast_ack <= 1'b0;
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check({32'h0, q}, {32'h0, x});
    endtask
    task automatic fill(input logic [51:0] a, input logic lst);
        @(posedge pclk);
        fill_valid <= 1'b1;
        fill_addr  <= a;
        fill_last  <= lst;
        @(posedge pclk);
        fill_valid <= 1'b0;
    endtask
    function automatic logic [5:0] size_lg(input logic [3:0] s);
        case (s)
            ptri_pkg::SZ_32M:  return ptri_pkg::LG_32M;
            ptri_pkg::SZ_512M: return ptri_pkg::LG_512M;
            ptri_pkg::SZ_1G:   return ptri_pkg::LG_1G;
            ptri_pkg::SZ_16G:  return ptri_pkg::LG_16G;
            ptri_pkg::SZ_64G:  return ptri_pkg::LG_64G;
            ptri_pkg::SZ_512G: return ptri_pkg::LG_512G;
            default:           return 6'h0;
        endcase
    endfunction
    function automatic logic [5:0] gran_lg(input logic [1:0] g);
        case (g)
            ptri_pkg::PGS_4K:  return ptri_pkg::LG_4K;
            ptri_pkg::PGS_16K: return ptri_pkg::LG_16K;
            ptri_pkg::PGS_64K: return ptri_pkg::LG_64K;
            default:           return 6'h0;
        endcase
    endfunction
    // Full launch with modelled outcome: 0 run, 1 undefined, 2 skipped
    task automatic launch(input logic [5:0] ctl, input logic [3:0] sz, input logic [39:0] ad,
                          input logic ll, input int d);
        logic [63:0] op;
        logic [51:0] base;
        logic [5:0]  lg;
        logic [1:0]  kind;
        op = {16'h0, sz, 4'h0, ad};
        lg = size_lg(sz);
        if (gran_lg(ctl[2:1]) > lg) lg = gran_lg(ctl[2:1]);
        base = {ad, 12'h0} & ~((52'h1 << gran_lg(ctl[2:1])) - 52'h1);
        if (!ctl[5] || ctl[4:3] != ptri_pkg::EL_TOP) kind = 2'h1;
        else if (size_lg(sz) == 6'h0 || gran_lg(ctl[2:1]) == 6'h0) kind = 2'h2;
        else if ((base & ((52'h1 << lg) - 52'h1)) != 52'h0) kind = 2'h2;
        else kind = 2'h0;
        dly = d;
        if (kind == 2'h0) begin
            fill(base + (52'h1 << lg) - 52'h1000, 1'b1);
            if (!ll) fill(base, 1'b0);
        end
        @(posedge pclk);
        nreq <= 0;
        apb(1'b1, ptri_pkg::OFF_OPER_LO, op[31:0]);
        if (kind == 2'h0) check(|entry_valid, 1'b1);
        apb(1'b1, ptri_pkg::OFF_OPER_HI, op[63:32]);
        apb(1'b1, ptri_pkg::OFF_ENCODING, {16'h0, ll ? 16'h7427 : 16'h7423});
        apb(1'b1, ptri_pkg::OFF_CTRL, {26'h0, ctl | 6'h01});
        repeat (3) @(posedge pclk);
        if (kind == 2'h0 && d > 2) begin
            apb(1'b1, ptri_pkg::OFF_OPER_LO, 32'hffff_ffff);
            check(e, 1'b1);
        end
        do apb(1'b0, ptri_pkg::OFF_STATUS, 32'h0); while (q[ptri_pkg::ST_BUSY] !== 1'b0);
        if (kind == 2'h0) begin
            exp_count++;
            check(q[5:0], {1'b1, ll, 4'h2});
            check(nreq, d + 1);
            check(cap_base, base);
            check({cap_last, cap_lg}, {ll, lg});
            check(entry_valid, 8'h0);
            rd_chk(ptri_pkg::OFF_BASE_HI, {12'h0, base[51:32]});
            rd_chk(ptri_pkg::OFF_SPAN, {26'h0, lg});
        end else begin
            check(q[5:0] & 6'h2f, (kind == 2'h1) ? 6'h06 : 6'h0a);
            check(nreq, 0);
        end
        rd_chk(ptri_pkg::OFF_COUNT, exp_count);
    endtask
    task automatic close_out();
        $display("checks=%0d errors=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (8000) @(posedge pclk);
        miscompares++;
        close_out();
    end
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, fill_valid, fill_addr, fill_last} = '0;
        {bcast_ack, presetn, miscompares, checks_done, nreq, dly, exp_count} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(ptri_pkg::OFF_CTRL, 32'h20);
        apb(1'b0, 8'h24, 32'h0);
        check({e, q}, {1'b1, 32'h0});
        for (int i = 0; i < 6; i++) begin
            pg = (i % 3 == 0) ? ptri_pkg::PGS_4K : (i % 3 == 1) ? ptri_pkg::PGS_16K : ptri_pkg::PGS_64K;
            launch({3'h7, pg, 1'b0}, 4'(4 + i), 40'h80_0000_0000 | (40'h1 << (size_lg(4'(4 + i)) - 12))
                   | {39'h0, pg != ptri_pkg::PGS_4K}, i[0], 2 * i);
        end
        launch(6'h38, 4'h5, 40'h2000, 1'b0, 1);
        launch(6'h30, 4'h4, 40'h0, 1'b1, 0);
        launch(6'h20, 4'h4, 40'h0, 1'b0, 0);
        launch(6'h18, 4'h4, 40'h0, 1'b1, 0);
        launch(6'h3e, 4'h4, 40'h0, 1'b1, 0);
        launch(6'h38, 4'ha, 40'h0, 1'b0, 0);
        launch(6'h38, 4'hf, 40'h0, 1'b1, 0);
        close_out();
    end
endmodule // tb_ptri_range_inval
